/* design/sfi_checker.sv */
/*
  Format-unit defect-list checker and inquiry command decoder with an
  APB register slave. Assumes firmware feeds header, descriptors and
  list-access conditions over APB and moves the inquiry data itself.
*/
// Chosen here: the APB interface to the registers and the register addresses.
// Behaviour
// R1 - With FOV set, DPRY, DCRT, STPF and DSP are accepted; others zero.
// R2 - DPRY zero uses the primary list; missing list follows stop-format.
// R3 - DPRY one ignores the primary list and never erases it.
// R4 - DCRT zero certifies and builds a list; one skips certification.
// R5 - Two triggers: list not found, or error reading initiator list.
// R6 - STPF zero: finish, then recovered error with matching code.
// R7 - STPF one: abort with media error and matching code.
// R8 - IP must be zero; target always uses its default fill pattern.
// R9 - DSP one: do not save mode-select parameters during format.
// R10 - Initiator sends vendor-unique bit as zero.
// R11 - List length gives descriptor byte count to receive.
// R12 - Descriptor: 3-byte cylinder, head, 4-byte index, MSB first.
// R13 - Descriptors must ascend; out of order gives check condition.
// R14 - All-ones index field reallocates the whole track; the code marks it with index 0fffffff instead.
// R15 - Inquiry runs when not ready or reserved; check only if impossible.
// R16 - Inquiry leaves a pending unit attention pending.
// R17 - Nonzero LUN returns not-present type in byte 0, no error.
// R18 - CDB: opcode, LUN high bits, EVPD bit 0, page byte 2, alloc byte 4.
// R19 - Page select: standard, supported list, serial, manufacturing.
// R20 - EVPD zero with nonzero page: illegal request, invalid CDB field.
// R21 - Allocation length zero transfers nothing and completes normally.
// R22 - Data-in ends at lesser of allocation and available bytes.
// R23 - EVPD one with unsupported page: illegal request.
`timescale 1ns/1ps
module sfi_checker #(
  parameter int DESC_MAX = 64
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fmtAbort,
  output logic fmtBusy,
  output logic inqDataEnd
);
  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sfi_pkg::sfi_fstate_t fst;
    logic [31:0] hdr;
    logic [1:0] cond;
    logic [31:0] descHi;
    logic [15:0] rcvd;
    logic [63:0] lastAddr;
    logic haveLast;
    logic orderErr;
    logic trackReq;
    logic certOn;
    logic usePlist;
    logic saveParams;
    logic [7:0] fStatus;
    logic [3:0] fKey;
    logic [7:0] fAsc;
    logic [31:0] cdb;
    logic [7:0] pageLen;
    logic uaPending;
    sfi_pkg::sfi_page_t page;
    logic lunAbsent;
    logic [7:0] iStatus;
    logic [3:0] iKey;
    logic [7:0] iAsc;
    logic [7:0] xferLimit;
    logic [7:0] xferCnt;
    logic xferEnd;
    logic fmtAbort;
    logic fmtBusy;
  } sfi_state_t;

  sfi_state_t st_reg;
  sfi_state_t st_next;

  logic access;
  logic wr;
  logic [63:0] newAddr;
  logic trig1;
  logic trig2;
  logic [7:0] evpdPage;
  logic evpd;
  logic [7:0] alloc;

  assign access = psel && penable && !st_reg.pready;
  assign wr = access && pwrite;
  // Descriptor address: cylinder, head, index, most significant first
  assign newAddr = {st_reg.descHi, pwdata}; // R12
  assign evpd = st_reg.cdb[8]; // R18
  assign evpdPage = st_reg.cdb[23:16]; // R18
  assign alloc = st_reg.cdb[31:24]; // R18

  always_comb begin
    st_next = st_reg;
    trig1 = 1'b0;
    trig2 = 1'b0;
    // -----------------------------------------------------------------
    // APB slave: one wait state, answer on the second access cycle
    // -----------------------------------------------------------------
    st_next.pready = access;
    st_next.pslverr = 1'b0;
    st_next.prdata = 32'h00000000;
    if (access && !pwrite) begin
      case (paddr)
        sfi_pkg::OFS_FMT_HDR: st_next.prdata = st_reg.hdr;
        sfi_pkg::OFS_FMT_COND: st_next.prdata = {30'h0, st_reg.cond};
        sfi_pkg::OFS_DESC_HI: st_next.prdata = st_reg.descHi;
        sfi_pkg::OFS_INQ_CDB: st_next.prdata = st_reg.cdb;
        sfi_pkg::OFS_PAGE_LEN: st_next.prdata = {24'h0, st_reg.pageLen};
        sfi_pkg::OFS_STATUS: st_next.prdata = {16'h0, st_reg.rcvd};
        sfi_pkg::OFS_FMT_RES: st_next.prdata = {st_reg.fStatus,
          4'h0, st_reg.fKey, st_reg.fAsc, 1'b0, st_reg.fst,
          st_reg.saveParams, st_reg.usePlist, st_reg.certOn,
          st_reg.trackReq, st_reg.orderErr};
        sfi_pkg::OFS_INQ_RES: st_next.prdata = {st_reg.iStatus,
          4'h0, st_reg.iKey, st_reg.iAsc, st_reg.lunAbsent,
          st_reg.uaPending, st_reg.page, 4'h0};
        sfi_pkg::OFS_XFER: st_next.prdata = {15'h0, st_reg.xferEnd,
          st_reg.xferCnt, st_reg.xferLimit};
        sfi_pkg::OFS_CTRL: st_next.prdata = 32'h00000000;
        default: st_next.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        sfi_pkg::OFS_FMT_HDR: st_next.hdr = pwdata;
        sfi_pkg::OFS_FMT_COND: st_next.cond = pwdata[1:0];
        sfi_pkg::OFS_DESC_HI: st_next.descHi = pwdata;
        sfi_pkg::OFS_INQ_CDB: st_next.cdb = pwdata;
        sfi_pkg::OFS_PAGE_LEN: st_next.pageLen = pwdata[7:0];
        sfi_pkg::OFS_CTRL, sfi_pkg::OFS_DESC_LO: ;
        default: st_next.pslverr = 1'b1;
      endcase
    end
    if (wr && paddr == sfi_pkg::OFS_CTRL
        && pwdata[sfi_pkg::CTRL_UA_SET])
      st_next.uaPending = 1'b1;

    // -----------------------------------------------------------------
    // Format header check and descriptor intake
    // -----------------------------------------------------------------
    trig1 = (!st_reg.hdr[sfi_pkg::HDR_DPRY] || !st_reg.hdr[sfi_pkg::HDR_CMPLST])
      && st_reg.cond[0]; // R5
    trig2 = (!st_reg.hdr[sfi_pkg::HDR_DPRY] || !st_reg.hdr[sfi_pkg::HDR_CMPLST])
      && st_reg.cond[1]; // R5
    case (st_reg.fst)
      sfi_pkg::FS_IDLE: begin
        if (wr && paddr == sfi_pkg::OFS_CTRL
            && pwdata[sfi_pkg::CTRL_FMT_START]) begin
          st_next.rcvd = 16'h0000;
          st_next.haveLast = 1'b0;
          st_next.orderErr = 1'b0;
          st_next.trackReq = 1'b0;
          st_next.fStatus = sfi_pkg::ST_GOOD;
          st_next.fKey = sfi_pkg::SK_NONE;
          st_next.fAsc = sfi_pkg::ASC_NONE;
          st_next.fmtAbort = 1'b0;
          // Options only honoured with FOV; other option bits must be 0
          if ((!st_reg.hdr[sfi_pkg::HDR_FOV]
               && (st_reg.hdr[sfi_pkg::HDR_DPRY] || st_reg.hdr[sfi_pkg::HDR_DCRT]
               || st_reg.hdr[sfi_pkg::HDR_STPF] || st_reg.hdr[sfi_pkg::HDR_DSP]))
              || st_reg.hdr[sfi_pkg::HDR_IP] || st_reg.hdr[sfi_pkg::HDR_VU]
              || st_reg.hdr[sfi_pkg::HDR_IMED]) begin // R1 R8 R10
            st_next.fStatus = sfi_pkg::ST_CHECK;
            st_next.fKey = sfi_pkg::SK_ILLEGAL;
            st_next.fAsc = sfi_pkg::ASC_BAD_CDB;
            st_next.fst = sfi_pkg::FS_DONE;
          end else begin
            st_next.usePlist = !st_reg.hdr[sfi_pkg::HDR_DPRY]; // R2 R3
            st_next.certOn = !st_reg.hdr[sfi_pkg::HDR_DCRT]; // R4
            st_next.saveParams = !st_reg.hdr[sfi_pkg::HDR_DSP]; // R9
            st_next.fmtBusy = 1'b1;
            st_next.fst = sfi_pkg::FS_LIST;
          end
        end
      end
      sfi_pkg::FS_LIST: begin
        if ((trig1 || trig2) && st_reg.hdr[sfi_pkg::HDR_STPF]) begin // R7
          st_next.fStatus = sfi_pkg::ST_CHECK;
          st_next.fKey = sfi_pkg::SK_MEDIA;
          st_next.fAsc = trig1 ? sfi_pkg::ASC_DL_NOT_FOUND
                               : sfi_pkg::ASC_DL_ERR;
          st_next.fmtAbort = 1'b1;
          st_next.fmtBusy = 1'b0;
          st_next.fst = sfi_pkg::FS_DONE;
        end else if (st_reg.rcvd >= st_reg.hdr[sfi_pkg::HDR_LEN_LSB +: 16]) begin
          st_next.fst = sfi_pkg::FS_RUN; // R11
        end else if (wr && paddr == sfi_pkg::OFS_DESC_LO) begin
          st_next.rcvd = st_reg.rcvd + 16'(sfi_pkg::DESC_BYTES); // R11
          if (st_reg.haveLast && newAddr <= st_reg.lastAddr)
            st_next.orderErr = 1'b1; // R13
          if (pwdata == sfi_pkg::TRACK_MARK)
            st_next.trackReq = 1'b1; // R14
          st_next.lastAddr = newAddr;
          st_next.haveLast = 1'b1;
        end
      end
      sfi_pkg::FS_RUN: begin
        // Media work runs outside; it reports the end through the control
        if (wr && paddr == sfi_pkg::OFS_CTRL
            && pwdata[sfi_pkg::CTRL_FMT_DONE]) begin
          st_next.fmtBusy = 1'b0;
          st_next.fst = sfi_pkg::FS_DONE;
          if (st_reg.orderErr) begin // R13
            st_next.fStatus = sfi_pkg::ST_CHECK;
            st_next.fKey = sfi_pkg::SK_ILLEGAL;
            st_next.fAsc = sfi_pkg::ASC_DL_ERR;
          end else if (trig1 || trig2) begin // R6
            st_next.fStatus = sfi_pkg::ST_CHECK;
            st_next.fKey = sfi_pkg::SK_RECOVERED;
            st_next.fAsc = trig1 ? sfi_pkg::ASC_DL_NOT_FOUND
                                 : sfi_pkg::ASC_DL_ERR;
          end
        end
      end
      sfi_pkg::FS_DONE: begin
        if (wr && paddr == sfi_pkg::OFS_CTRL
            && pwdata[sfi_pkg::CTRL_FMT_START])
          st_next.fst = sfi_pkg::FS_IDLE;
      end
      default: st_next.fst = sfi_pkg::FS_IDLE;
    endcase

    // -----------------------------------------------------------------
    // Inquiry decode; runs whatever the ready or reservation state R15
    // -----------------------------------------------------------------
    if (wr && paddr == sfi_pkg::OFS_CTRL
        && pwdata[sfi_pkg::CTRL_INQ_START]) begin
      // Unit attention is left untouched R16
      st_next.lunAbsent = st_reg.cdb[15:13] != 3'b000; // R17
      st_next.iStatus = sfi_pkg::ST_GOOD;
      st_next.iKey = sfi_pkg::SK_NONE;
      st_next.iAsc = sfi_pkg::ASC_NONE;
      st_next.xferCnt = 8'h00;
      st_next.page = sfi_pkg::SEL_STD;
      if (!evpd && evpdPage != sfi_pkg::PAGE_STD) begin // R20
        st_next.iStatus = sfi_pkg::ST_CHECK;
        st_next.iKey = sfi_pkg::SK_ILLEGAL;
        st_next.iAsc = sfi_pkg::ASC_BAD_CDB;
      end else if (evpd) begin // R19
        case (evpdPage)
          sfi_pkg::PAGE_STD: st_next.page = sfi_pkg::SEL_LIST;
          sfi_pkg::PAGE_SERIAL: st_next.page = sfi_pkg::SEL_SERIAL;
          sfi_pkg::PAGE_MFG: st_next.page = sfi_pkg::SEL_MFG;
          default: begin // R23
            st_next.iStatus = sfi_pkg::ST_CHECK;
            st_next.iKey = sfi_pkg::SK_ILLEGAL;
            st_next.iAsc = sfi_pkg::ASC_BAD_CDB;
          end
        endcase
      end
      // Transfer limit is the lesser of allocation and page length R22
      st_next.xferLimit = (alloc < st_reg.pageLen) ? alloc : st_reg.pageLen;
      // A rejected inquiry sends no data at all
      st_next.xferEnd = (alloc == 8'h00) || (st_reg.pageLen == 8'h00)
        || (st_next.iStatus != sfi_pkg::ST_GOOD); // R15 R21
    end else if (wr && paddr == sfi_pkg::OFS_CTRL
                 && pwdata[sfi_pkg::CTRL_XFER_BYTE] && !st_reg.xferEnd) begin
      st_next.xferCnt = st_reg.xferCnt + 8'h01;
      st_next.xferEnd = (st_reg.xferCnt + 8'h01) >= st_reg.xferLimit; // R22
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign fmtAbort = st_reg.fmtAbort;
  assign fmtBusy = st_reg.fmtBusy;
  assign inqDataEnd = st_reg.xferEnd;
endmodule

/* pkg/sfi_pkg.sv */
/*
  Constants for the format-header and inquiry command checker.
  Assumes one clock domain and an APB register slave in the checker.
*/
package sfi_pkg;
  // -------------------------------------------------------------------
  // Register byte offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FMT_HDR = 8'h04;
  localparam logic [7:0] OFS_FMT_COND = 8'h08;
  localparam logic [7:0] OFS_DESC_HI = 8'h0c;
  localparam logic [7:0] OFS_DESC_LO = 8'h10;
  localparam logic [7:0] OFS_INQ_CDB = 8'h14;
  localparam logic [7:0] OFS_PAGE_LEN = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_FMT_RES = 8'h20;
  localparam logic [7:0] OFS_INQ_RES = 8'h24;
  localparam logic [7:0] OFS_XFER = 8'h28;

  // -------------------------------------------------------------------
  // Control register bits (write one to act; CTRL_DESC_PUSH has no effect)
  // -------------------------------------------------------------------
  localparam int CTRL_FMT_START = 0;
  localparam int CTRL_DESC_PUSH = 1;
  localparam int CTRL_FMT_DONE = 2;
  localparam int CTRL_INQ_START = 3;
  localparam int CTRL_XFER_BYTE = 4;
  localparam int CTRL_UA_SET = 5;

  // -------------------------------------------------------------------
  // Defect list header, byte 1 bit positions and length field
  // -------------------------------------------------------------------
  localparam int HDR_FOV = 7;
  localparam int HDR_DPRY = 6;
  localparam int HDR_DCRT = 5;
  localparam int HDR_STPF = 4;
  localparam int HDR_IP = 3;
  localparam int HDR_DSP = 2;
  localparam int HDR_IMED = 1;
  localparam int HDR_VU = 0;
  localparam int HDR_LEN_LSB = 8;
  localparam int HDR_CMPLST = 24;
  localparam int DESC_BYTES = 8;

  // Track-reallocation marker in the bytes-from-index field
  localparam logic [31:0] TRACK_MARK = 32'h0fffffff;

  // -------------------------------------------------------------------
  // Inquiry descriptor block fields (packed bytes 0,1,2,4)
  // -------------------------------------------------------------------
  localparam logic [7:0] INQ_OPCODE = 8'h12;
  localparam logic [7:0] PAGE_STD = 8'h00;
  localparam logic [7:0] PAGE_SERIAL = 8'h80;
  localparam logic [7:0] PAGE_MFG = 8'he0;
  localparam logic [7:0] LUN_ABSENT = 8'h7f;

  // -------------------------------------------------------------------
  // Status codes
  // -------------------------------------------------------------------
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_RECOVERED = 4'h1;
  localparam logic [3:0] SK_MEDIA = 4'h3;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_DL_ERR = 8'h19;
  localparam logic [7:0] ASC_BAD_CDB = 8'h24;
  localparam logic [7:0] ASC_DL_NOT_FOUND = 8'h1c;

  typedef enum logic [1:0] {
    SEL_STD = 2'b00,
    SEL_LIST = 2'b01,
    SEL_SERIAL = 2'b10,
    SEL_MFG = 2'b11
  } sfi_page_t;

  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_LIST = 2'b01,
    FS_RUN = 2'b10,
    FS_DONE = 2'b11
  } sfi_fstate_t;
endpackage

/* test/sfi_assert_checker.sv */
/*
  Port assertions for the format and inquiry command checker.
  Assumes it is bound onto every sfi_checker instance.
*/
`timescale 1ns/1ps
module sfi_assert_chk #(
  parameter int DESC_MAX = 64
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fmtAbort,
  input wire logic fmtBusy,
  input wire logic inqDataEnd
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_wait;
    (psel && penable && !pready && clkEn) |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_err_ack;
    pslverr |-> pready;
  endproperty
  a_err_ack: assert property (p_err_ack) else $error("stray pslverr");
  property p_unmapped;
    (pready && psel && paddr > 8'h28) |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no pslverr");
  property p_mapped;
    (pready && psel && paddr <= 8'h28) |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("bad pslverr");
  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  property p_rst;
    disable iff (1'b0) !rst_n |=> !(pready || fmtAbort || fmtBusy ||
      inqDataEnd);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
  property p_abort;
    fmtAbort |-> !fmtBusy;
  endproperty
  a_abort: assert property (p_abort) else $error("busy on abort");
  property p_freeze;
    !clkEn |=> $stable({fmtAbort, fmtBusy, inqDataEnd});
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while frozen");
  c_abort: cover property (fmtAbort);
  c_end: cover property ($rose(inqDataEnd));
  c_err: cover property (pslverr);
endmodule
bind sfi_checker sfi_assert_chk #(.DESC_MAX(DESC_MAX)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fmtAbort(fmtAbort), .fmtBusy(fmtBusy), .inqDataEnd(inqDataEnd));

/* test/sfi_apb_host.sv */
/*
  APB master standing for the initiator side: builds headers and
  command blocks. Assumes the bench calls its tasks after an edge.
*/
`timescale 1ns/1ps
module sfi_apb_host (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e,
    output bit ok);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    ok = 0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) begin
        ok = 1;
        q = prdata;
        e = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show a changed value, not the old one
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // FOV set; DPRY, DCRT, STPF and DSP from opt; IMED, pattern and vendor bit left zero
  function automatic logic [31:0] hdr(input logic [3:0] opt,
    input logic [15:0] len);
    hdr = 32'h0;
    hdr[sfi_pkg::HDR_FOV] = 1'b1;
    {hdr[sfi_pkg::HDR_DPRY], hdr[sfi_pkg::HDR_DCRT]} = opt[3:2];
    {hdr[sfi_pkg::HDR_STPF], hdr[sfi_pkg::HDR_DSP]} = opt[1:0];
    hdr[sfi_pkg::HDR_IP] = 1'b0;
    hdr[sfi_pkg::HDR_VU] = 1'b0;
    hdr[sfi_pkg::HDR_LEN_LSB +: 16] = len;
  endfunction
  function automatic logic [31:0] cdb(input logic [2:0] lun,
    input logic evpd, input logic [7:0] page, input logic [7:0] alloc);
    cdb = {alloc, page, lun, 4'h0, evpd, sfi_pkg::INQ_OPCODE};
  endfunction
endmodule

/* test/sfi_checker_tb_top.sv */
/*
  Self-checking bench for the format and inquiry command checker.
  Assumes the APB host model and the bound assertion checker.
*/
`timescale 1ns/1ps
module sfi_checker_tb_top;
  typedef struct {
    logic [2:0] lun;
    logic evpd;
    logic [7:0] page;
    logic [7:0] alloc;
    logic [7:0] plen;
    int n;
    logic ua;
    logic [31:0] res;
  } sfi_row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic fmtAbort, fmtBusy, inqDataEnd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  int err_total = 0;
  int checks_done = 0;
  sfi_row_t rows [7] = '{
    '{3'd0, 1'b0, 8'h00, 8'd5, 8'd36, 5, 1'b0, 32'h00000000},
    '{3'd0, 1'b1, 8'h80, 8'd40, 8'd8, 8, 1'b0, 32'h00000020},
    '{3'd0, 1'b1, 8'h00, 8'd0, 8'd7, 0, 1'b0, 32'h00000010},
    '{3'd0, 1'b1, 8'he0, 8'd3, 8'd3, 3, 1'b1, 32'h00000070},
    '{3'd2, 1'b0, 8'h00, 8'd2, 8'd36, 2, 1'b0, 32'h000000c0},
    '{3'd0, 1'b0, 8'h01, 8'd4, 8'd36, 0, 1'b0, 32'h02052440},
    '{3'd0, 1'b1, 8'h83, 8'd4, 8'd36, 0, 1'b0, 32'h02052440}};
  always #2 mclk = ~mclk;
  sfi_apb_host host (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  sfi_checker dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fmtAbort(fmtAbort), .fmtBusy(fmtBusy),
    .inqDataEnd(inqDataEnd));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic eexp);
    logic e;
    bit ok;
    host.xfer(w, a, d, rdv, e, ok);
    if (!ok) begin
      err_total++;
      summarize();
    end
    check({31'h0, e}, {31'h0, eexp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic push(input logic [23:0] cyl, input logic [7:0] head,
    input logic [31:0] idx);
    wr(sfi_pkg::OFS_DESC_HI, {cyl, head});
    wr(sfi_pkg::OFS_DESC_LO, idx);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int r = 0; r < 7; r++) begin
      if (rows[r].ua) wr(sfi_pkg::OFS_CTRL, 32'h1 << sfi_pkg::CTRL_UA_SET);
      wr(sfi_pkg::OFS_PAGE_LEN, {24'h0, rows[r].plen});
      wr(sfi_pkg::OFS_INQ_CDB, host.cdb(rows[r].lun, rows[r].evpd,
        rows[r].page, rows[r].alloc));
      wr(sfi_pkg::OFS_CTRL, 32'h1 << sfi_pkg::CTRL_INQ_START);
      bus(1'b0, sfi_pkg::OFS_INQ_RES, 32'h0, 1'b0);
      check(rdv, rows[r].res);
      for (int i = 0; i < rows[r].n; i++) begin
        settle();
        check({31'h0, inqDataEnd}, 32'h0);
        wr(sfi_pkg::OFS_CTRL, 32'h1 << sfi_pkg::CTRL_XFER_BYTE);
      end
      settle();
      check({31'h0, inqDataEnd}, 32'h1);
      $display("test inquiry row %0d done", r);
    end
    wr(sfi_pkg::OFS_FMT_HDR, host.hdr(4'b0010, 16'h10));
    wr(sfi_pkg::OFS_FMT_COND, 32'h1);
    wr(sfi_pkg::OFS_CTRL, 32'h1 << sfi_pkg::CTRL_FMT_START);
    settle();
    check({31'h0, fmtAbort}, 32'h1);
    check({31'h0, fmtBusy}, 32'h0);
    bus(1'b0, sfi_pkg::OFS_FMT_RES, 32'h0, 1'b0);
    check(rdv, 32'h02031c7c);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    settle();
    check({29'h0, fmtAbort, fmtBusy, inqDataEnd}, 32'h0);
    $display("test abort and reset done");
    wr(sfi_pkg::OFS_FMT_HDR, host.hdr(4'b0000, 16'h10));
    wr(sfi_pkg::OFS_FMT_COND, 32'h2);
    wr(sfi_pkg::OFS_CTRL, 32'h1 << sfi_pkg::CTRL_FMT_START);
    settle();
    check({30'h0, fmtBusy, fmtAbort}, 32'h2);
    push(24'h000010, 8'h01, 32'h00000100);
    push(24'h000020, 8'h00, sfi_pkg::TRACK_MARK);
    bus(1'b0, sfi_pkg::OFS_STATUS, 32'h0, 1'b0);
    check(rdv, 32'h10);
    @(posedge mclk);
    clkEn <= 1'b0;
    repeat (4) @(posedge mclk);
    clkEn <= 1'b1;
    check({31'h0, fmtBusy}, 32'h1);
    wr(sfi_pkg::OFS_CTRL, 32'h1 << sfi_pkg::CTRL_FMT_DONE);
    settle();
    check({30'h0, fmtBusy, fmtAbort}, 32'h0);
    bus(1'b0, sfi_pkg::OFS_FMT_RES, 32'h0, 1'b0);
    check(rdv, 32'h0201197e);
    bus(1'b0, 8'hfc, 32'h0, 1'b1);
    $display("test format run and unmapped access done");
    summarize();
  end
endmodule
